// ===== rtl/mte_enc_chan.sv
// one quadrature channel: decode, interpolation, wrap and reference preset
module mte_enc_chan
  import mte_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // encoder pins
  input wire logic trk_a_i,
  input wire logic trk_b_i,
  input wire logic ref_i,
  // configuration and commands
  input wire logic enable_i,
  input wire mte_enc_cfg_s cfg_i,
  input wire logic preset_wr_i,
  input wire logic soft_load_i,
  input wire logic rearm_i,
  // state
  output logic [31:0] pos_o,
  output logic move_o,
  output logic marker_seen_o
);
  logic [2:0] meta;
  logic [2:0] s;
  logic [2:0] p;
  logic a_chg;
  logic b_chg;
  logic up;
  logic ref_rise;
  logic load_ref;
  logic load_sw;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      meta <= 3'h0;
      s <= 3'h0;
      p <= 3'h0;
    end
    else
    begin
      meta <= {ref_i, trk_b_i, trk_a_i};
      s <= meta;
      p <= s;
    end
  end

  assign a_chg = s[0] ^ p[0];
  assign b_chg = s[1] ^ p[1];
  assign up = p[0] ^ s[1];
  assign ref_rise = s[2] & ~p[2];
  always_comb
  begin
    case (cfg_i.depth)
      DEPTH_SINGLE: move_o = enable_i & a_chg & s[0] & ~b_chg;
      DEPTH_DUAL: move_o = enable_i & a_chg & ~b_chg;
      default: move_o = enable_i & (a_chg ^ b_chg);
    endcase
  end

  assign load_ref = enable_i & ref_rise & ((cfg_i.refmode == REF_EVERY) |
                    ((cfg_i.refmode == REF_ONE) & ~marker_seen_o));
  assign load_sw = soft_load_i & (cfg_i.refmode == REF_NONE);

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      pos_o <= 32'h0000_0000;
    else if (load_ref | load_sw)
      pos_o <= cfg_i.preset;
    else if (move_o && up)
      pos_o <= (pos_o >= cfg_i.wrap) ? 32'h0000_0000 : pos_o + 32'h1;
    else if (move_o)
      pos_o <= (pos_o == 32'h0000_0000) ? cfg_i.wrap : pos_o - 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      marker_seen_o <= 1'b0;
    else if (load_ref && cfg_i.refmode == REF_ONE)
      marker_seen_o <= 1'b1;
    else if (preset_wr_i || (rearm_i && cfg_i.refmode == REF_ONE))
      marker_seen_o <= 1'b0;
  end

  chk_oneshot_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    marker_seen_o && cfg_i.refmode == REF_ONE && !preset_wr_i && !rearm_i
    && !soft_load_i |=> $stable(pos_o) || $past(move_o))
    else $error("one-shot marker reloaded counter");
  chk_none_ignores_ref: assert property (@(posedge clk_i) disable iff (!nrst_i)
    cfg_i.refmode == REF_NONE && !soft_load_i && !move_o |=> $stable(pos_o))
    else $error("counter moved without cause");
endmodule // mte_enc_chan

// ===== rtl/mte_pkg.sv
// shared constants, enums and carriers for the trigger and encoder unit
package mte_pkg;
  localparam int NUM_ENC = 3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COUNT = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STEP = 8'h0C;
  localparam logic [7:0] REG_WLO = 8'h10;
  localparam logic [7:0] REG_WHI = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_SCNT = 8'h1C;
  localparam logic [7:0] REG_TSTAMP = 8'h20;
  localparam logic [7:0] REG_REMAIN = 8'h24;
  localparam logic [7:0] REG_ENC_BASE = 8'h40;
  localparam logic [7:0] ENC_STRIDE = 8'h10;
  localparam logic [3:0] ENC_CFG_OFS = 4'h0;
  localparam logic [3:0] ENC_PRESET_OFS = 4'h4;
  localparam logic [3:0] ENC_WRAP_OFS = 4'h8;
  localparam logic [3:0] ENC_POS_OFS = 4'hC;
  // control register fields
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_MODE_BIT = 3;
  localparam int CTRL_POL_BIT = 4;
  localparam int CTRL_PLACE_BIT = 5;
  localparam int CTRL_CHAN_LSB = 6;
  // command register bits, write-only pulses
  localparam int CMD_SOFT_BIT = 0;
  localparam int CMD_LOAD_LSB = 1;
  localparam int CMD_REARM_LSB = 4;
  localparam int CMD_CLR_TS_BIT = 7;
  localparam int CMD_CLR_SC_BIT = 8;
  // encoder config fields
  localparam int ENC_DEPTH_LSB = 0;
  localparam int ENC_REF_LSB = 2;
  // reset values: edge, high polarity, acquisition placement, one channel
  localparam logic [7:0] CTRL_RST = 8'h50;
  localparam logic [31:0] COUNT_RST = 32'h0000_0001;
  localparam logic [31:0] COUNT_NONE = 32'h0000_0000;
  localparam logic [31:0] COUNT_INF = 32'hFFFF_FFFF;
  localparam logic [31:0] WIN_HI_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] WRAP_RST = 32'hFFFF_FFFF;
  localparam logic [1:0] DEPTH_SINGLE = 2'h1;
  localparam logic [1:0] DEPTH_DUAL = 2'h2;
  localparam logic [1:0] DEPTH_QUAD = 2'h3;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_SYNC, SRC_PIN, SRC_SOFT, SRC_ENC1, SRC_ENC2
  } mte_src_e;
  typedef enum logic [1:0] {REF_NONE, REF_ONE, REF_EVERY} mte_ref_e;
  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_ENDLESS} mte_state_e;

  typedef struct packed {
    logic [1:0] depth;
    mte_ref_e refmode;
    logic [31:0] preset;
    logic [31:0] wrap;
  } mte_enc_cfg_s;
endpackage

// ===== rtl/mte_sync_edge.sv
// two-stage synchroniser with rise and fall pulses
module mte_sync_edge
  import mte_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // pin and conditioned outputs
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic meta;
  logic prev;

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      meta <= 1'b0;
      level_o <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= pin_i;
      level_o <= meta;
      prev <= level_o;
    end
  end

  assign rise_o = level_o & ~prev;
  assign fall_o = ~level_o & prev;
endmodule // mte_sync_edge

// ===== rtl/mte_trig_unit.sv
// trigger source selection, release counting and encoder position triggers
module mte_trig_unit
  import mte_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // trigger pins
  input wire logic differential_sync_input_i,
  input wire logic single_ended_trigger_pin_i,
  // encoder pins
  input wire logic [NUM_ENC-1:0] enc_a_i,
  input wire logic [NUM_ENC-1:0] enc_b_i,
  input wire logic [NUM_ENC-1:0] enc_ref_i,
  // measurement core
  input wire logic sample_tick_i,
  output logic release_o,
  output logic avg_restart_o,
  output logic acq_gate_o
);
  logic [7:0] ctrl;
  logic [31:0] values_per_trigger;
  logic [30:0] position_step_interval;
  logic [31:0] position_window_low;
  logic [31:0] position_window_high;
  mte_enc_cfg_s enc_cfg [NUM_ENC];
  logic [31:0] sample_counter;
  logic [31:0] timestamp;
  logic [31:0] remain;
  logic [30:0] step_acc;
  logic clr_ts_pend;
  logic clr_sc_pend;
  mte_state_e state;
  logic level_prev;

  mte_src_e trigger_origin_select;
  logic edge_or_level_select;
  logic trigger_polarity;
  logic trigger_placement;
  logic [1:0] active_channel_count;
  logic cmd_wr;
  logic [NUM_ENC-1:0] preset_wr;
  logic [NUM_ENC-1:0] chan_en;
  logic [31:0] pos [NUM_ENC];
  logic [NUM_ENC-1:0] move;
  logic [NUM_ENC-1:0] seen;
  logic sync_lvl, sync_rise, sync_fall;
  logic pin_lvl, pin_rise, pin_fall;
  logic src_lvl, src_rise, src_fall;
  logic pin_src;
  logic level_on;
  logic soft_trigger_command;
  logic enc_src;
  logic [31:0] enc_pos;
  logic enc_move;
  logic enc_inside;
  logic enc_step_hit;
  logic trig_event;
  logic trig_edge;
  logic release_now;
  logic endless_level;

  function automatic logic enc_reg_hit(input logic [7:0] a, input int ch,
                                       input logic [3:0] ofs);
    enc_reg_hit = a == (REG_ENC_BASE + 8'(ch) * ENC_STRIDE + {4'h0, ofs});
  endfunction

  function automatic logic in_window(input logic [31:0] p,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
    in_window = (p >= lo) && (p <= hi);
  endfunction

  assign trigger_origin_select = mte_src_e'(ctrl[CTRL_SRC_LSB +: 3]);
  assign edge_or_level_select = ctrl[CTRL_MODE_BIT];
  assign trigger_polarity = ctrl[CTRL_POL_BIT];
  assign trigger_placement = ctrl[CTRL_PLACE_BIT];
  assign active_channel_count = ctrl[CTRL_CHAN_LSB +: 2];
  assign cmd_wr = wr_i && addr_i == REG_CMD;
  assign soft_trigger_command = cmd_wr && wdata_i[CMD_SOFT_BIT];

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl <= CTRL_RST;
      values_per_trigger <= COUNT_RST;
      position_step_interval <= 31'h0000_0000;
      position_window_low <= 32'h0000_0000;
      position_window_high <= WIN_HI_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        REG_CTRL: ctrl <= wdata_i[7:0];
        REG_COUNT: values_per_trigger <= wdata_i;
        REG_STEP: position_step_interval <= wdata_i[30:0];
        REG_WLO: position_window_low <= wdata_i;
        REG_WHI: position_window_high <= wdata_i;
        default: ;
      endcase
    end
  end

  for (genvar i = 0; i < NUM_ENC; i++)
  begin : g_enc
    assign preset_wr[i] = wr_i && enc_reg_hit(addr_i, i, ENC_PRESET_OFS);
    assign chan_en[i] = active_channel_count > 2'(i);

    always_ff @(posedge clk_i)
    begin
      if (!nrst_i)
      begin
        enc_cfg[i].depth <= DEPTH_QUAD;
        enc_cfg[i].refmode <= REF_NONE;
        enc_cfg[i].preset <= 32'h0000_0000;
        enc_cfg[i].wrap <= WRAP_RST;
      end
      else if (wr_i && enc_reg_hit(addr_i, i, ENC_CFG_OFS))
      begin
        enc_cfg[i].depth <= wdata_i[ENC_DEPTH_LSB +: 2];
        enc_cfg[i].refmode <= mte_ref_e'(wdata_i[ENC_REF_LSB +: 2]);
      end
      else if (preset_wr[i])
        enc_cfg[i].preset <= wdata_i;
      else if (wr_i && enc_reg_hit(addr_i, i, ENC_WRAP_OFS))
        enc_cfg[i].wrap <= wdata_i;
    end

    mte_enc_chan u_chan (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .trk_a_i(enc_a_i[i]),
      .trk_b_i(enc_b_i[i]),
      .ref_i(enc_ref_i[i]),
      .enable_i(chan_en[i]),
      .cfg_i(enc_cfg[i]),
      .preset_wr_i(preset_wr[i]),
      .soft_load_i(cmd_wr && wdata_i[CMD_LOAD_LSB + i]),
      .rearm_i(cmd_wr && wdata_i[CMD_REARM_LSB + i]),
      .pos_o(pos[i]),
      .move_o(move[i]),
      .marker_seen_o(seen[i])
    );
  end

  mte_sync_edge u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(differential_sync_input_i),
    .level_o(sync_lvl),
    .rise_o(sync_rise),
    .fall_o(sync_fall)
  );

  mte_sync_edge u_pin (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(single_ended_trigger_pin_i),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // source selection: only the chosen origin can ever fire
  assign pin_src = trigger_origin_select == SRC_SYNC
                   || trigger_origin_select == SRC_PIN;
  assign src_lvl = (trigger_origin_select == SRC_SYNC) ? sync_lvl : pin_lvl;
  assign src_rise = (trigger_origin_select == SRC_SYNC) ? sync_rise : pin_rise;
  assign src_fall = (trigger_origin_select == SRC_SYNC) ? sync_fall : pin_fall;
  assign level_on = pin_src && edge_or_level_select
                    && (src_lvl == trigger_polarity);
  assign enc_src = trigger_origin_select == SRC_ENC1
                   || trigger_origin_select == SRC_ENC2;
  assign enc_pos = (trigger_origin_select == SRC_ENC2) ? pos[1] : pos[0];
  assign enc_move = (trigger_origin_select == SRC_ENC2) ? move[1] : move[0];
  assign enc_inside = enc_src
                      && in_window(enc_pos, position_window_low,
                                   position_window_high);
  // the window is judged on the position before the step is applied
  assign enc_step_hit = enc_inside && enc_move
                        && position_step_interval != 31'h0000_0000
                        && step_acc + 31'h1 >= position_step_interval;

  // a trigger event starts a burst; level triggering gates continuously
  assign trig_event = (pin_src && !edge_or_level_select
                       && (trigger_polarity ? src_rise : src_fall))
                      || (soft_trigger_command
                          && trigger_origin_select == SRC_SOFT)
                      || enc_step_hit;
  assign trig_edge = trig_event || (level_on && !level_prev);
  // zero step size streams while inside the window, like a level gate
  assign endless_level = level_on || (enc_inside
                         && position_step_interval == 31'h0000_0000);
  assign release_now = sample_tick_i
                       && (state != ST_IDLE || endless_level);

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      step_acc <= 31'h0000_0000;
    else if (!enc_src || enc_step_hit)
      step_acc <= 31'h0000_0000;
    else if (enc_move)
      step_acc <= step_acc + 31'h1;
  end

  // burst state: counted or unbounded release after an event
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      state <= ST_IDLE;
      remain <= 32'h0000_0000;
    end
    else if (values_per_trigger == COUNT_NONE
             || trigger_origin_select == SRC_NONE)
    begin
      state <= ST_IDLE;
      remain <= 32'h0000_0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (trig_event && values_per_trigger == COUNT_INF)
            state <= ST_ENDLESS;
          else if (trig_event)
          begin
            state <= ST_BURST;
            remain <= values_per_trigger;
          end
        ST_BURST:
          if (trig_event)
            remain <= values_per_trigger;
          else if (release_now && remain == 32'h0000_0001)
          begin
            state <= ST_IDLE;
            remain <= 32'h0000_0000;
          end
          else if (release_now)
            remain <= remain - 32'h1;
        ST_ENDLESS: ;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      release_o <= 1'b0;
      avg_restart_o <= 1'b0;
      acq_gate_o <= 1'b0;
      level_prev <= 1'b0;
    end
    else
    begin
      release_o <= release_now;
      // acquisition placement drops the pending average at the trigger;
      // output placement keeps it so pre-trigger samples count
      avg_restart_o <= trig_edge && !trigger_placement;
      acq_gate_o <= !trigger_placement
                    && (state != ST_IDLE || endless_level);
      level_prev <= level_on;
    end
  end

  // clear requests wait for the next trigger edge; a new request wins
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      clr_ts_pend <= 1'b0;
      clr_sc_pend <= 1'b0;
    end
    else
    begin
      if (cmd_wr && wdata_i[CMD_CLR_TS_BIT])
        clr_ts_pend <= 1'b1;
      else if (trig_edge)
        clr_ts_pend <= 1'b0;
      if (cmd_wr && wdata_i[CMD_CLR_SC_BIT])
        clr_sc_pend <= 1'b1;
      else if (trig_edge)
        clr_sc_pend <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      timestamp <= 32'h0000_0000;
      sample_counter <= 32'h0000_0000;
    end
    else
    begin
      if (trig_edge && clr_ts_pend)
        timestamp <= 32'h0000_0000;
      else if (sample_tick_i)
        timestamp <= timestamp + 32'h1;
      if (trig_edge && clr_sc_pend)
        sample_counter <= 32'h0000_0000;
      else if (release_now)
        sample_counter <= sample_counter + 32'h1;
    end
  end

  // read port: data stand only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i || !rd_i)
      rdata_o <= 32'h0000_0000;
    else
    begin
      case (addr_i)
        REG_CTRL: rdata_o <= {24'h00_0000, ctrl};
        REG_COUNT: rdata_o <= values_per_trigger;
        REG_STEP: rdata_o <= {1'b0, position_step_interval};
        REG_WLO: rdata_o <= position_window_low;
        REG_WHI: rdata_o <= position_window_high;
        REG_STATUS: rdata_o <= {24'h00_0000, clr_sc_pend, clr_ts_pend,
                                seen, state, level_on};
        REG_SCNT: rdata_o <= sample_counter;
        REG_TSTAMP: rdata_o <= timestamp;
        REG_REMAIN: rdata_o <= remain;
        default: rdata_o <= 32'h0000_0000;
      endcase
      for (int i = 0; i < NUM_ENC; i++)
      begin
        if (enc_reg_hit(addr_i, i, ENC_CFG_OFS))
          rdata_o <= {28'h000_0000, enc_cfg[i].refmode, enc_cfg[i].depth};
        if (enc_reg_hit(addr_i, i, ENC_PRESET_OFS))
          rdata_o <= enc_cfg[i].preset;
        if (enc_reg_hit(addr_i, i, ENC_WRAP_OFS))
          rdata_o <= enc_cfg[i].wrap;
        if (enc_reg_hit(addr_i, i, ENC_POS_OFS))
          rdata_o <= pos[i];
      end
    end
  end

  chk_soft_gated: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == ST_IDLE && soft_trigger_command
    && trigger_origin_select != SRC_SOFT && !endless_level
    && !(pin_src && (sync_rise | sync_fall | pin_rise | pin_fall))
    && !enc_move |=> state == ST_IDLE)
    else $error("soft trigger fired with other source");
  chk_none_stops: assert property (@(posedge clk_i) disable iff (!nrst_i)
    values_per_trigger == COUNT_NONE |=> state == ST_IDLE)
    else $error("burst kept running with count none");
  chk_burst_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == ST_IDLE && trig_event && values_per_trigger != COUNT_NONE
    && values_per_trigger != COUNT_INF && trigger_origin_select != SRC_NONE
    |=> state == ST_BURST && remain == $past(values_per_trigger))
    else $error("burst count not loaded");
  chk_count_down: assert property (@(posedge clk_i) disable iff (!nrst_i)
    state == ST_BURST && release_now && !trig_event && remain > 32'h1
    && values_per_trigger != COUNT_NONE && trigger_origin_select != SRC_NONE
    |=> remain == $past(remain) - 32'h1 && release_o)
    else $error("remaining count not decremented");
  chk_restart_place: assert property (@(posedge clk_i) disable iff (!nrst_i)
    trig_edge |=> avg_restart_o == !$past(trigger_placement))
    else $error("average restart ignores placement");
  chk_clear_wait: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clr_sc_pend && !trig_edge && release_now
    |=> sample_counter == $past(sample_counter) + 32'h1)
    else $error("sample counter cleared before trigger");
  chk_level_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    level_on && sample_tick_i |=> release_o)
    else $error("level trigger did not release");
  chk_window_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enc_src && !enc_inside |-> !enc_step_hit)
    else $error("encoder trigger outside window");
  chk_place_reset: assert property (@(posedge clk_i)
    !nrst_i |=> !trigger_placement)
    else $error("placement not acquisition after reset");
endmodule // mte_trig_unit

// ===== verification/mte_far_model.sv
// quadrature encoder and trigger pulse source facing the unit
module mte_far_model (
  // encoder tracks
  output logic [2:0] enc_a_o,
  output logic [2:0] enc_b_o,
  output logic [2:0] enc_ref_o,
  // trigger pins
  output logic sync_o,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int ph = 0;
  initial
  begin
    {enc_a_o, enc_b_o, enc_ref_o} = '0;
    sync_o = 1'b0;
    pin_o = 1'b0;
  end
  // one track per step, b leads a when moving up; slow against the clock
  task automatic step(input bit up, input int n);
    #5;
    for (int i = 0; i < n; i++)
    begin
      ph = up ? ph + 3 : ph + 1;
      enc_a_o[0] = (ph % 4 == 1) || (ph % 4 == 2);
      enc_b_o[0] = (ph % 4 >= 2);
      #250;
    end
  endtask
  task automatic set_pin(input logic v);
    #5;
    pin_o = v;
    #250;
  endtask
  task automatic set_sync(input logic v);
    #5;
    sync_o = v;
    #250;
  endtask
  // one marker pulse on the first channel's reference track
  task automatic mark();
    #5;
    enc_ref_o[0] = 1'b1;
    #250;
    enc_ref_o[0] = 1'b0;
    #250;
  endtask
endmodule // mte_far_model

// ===== verification/test_measurement_trigger_and_encoder_unit.sv
// self-checking bench for the trigger and encoder unit
module test_measurement_trigger_and_encoder_unit
  import mte_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic tick = 1'b0, rel, avg, gate, sync, pin;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o, v;
  logic [2:0] ea, eb, er;
  int errors = 0, tests_run = 0, n_rel = 0, n_avg = 0;
  mte_far_model u_far (.enc_a_o(ea), .enc_b_o(eb), .enc_ref_o(er),
    .sync_o(sync), .pin_o(pin));
  mte_trig_unit DUT (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .differential_sync_input_i(sync), .single_ended_trigger_pin_i(pin),
    .enc_a_i(ea), .enc_b_i(eb), .enc_ref_i(er), .sample_tick_i(tick),
    .release_o(rel), .avg_restart_o(avg), .acq_gate_o(gate));
  initial
  begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (rel === 1'b1) n_rel++;
    if (avg === 1'b1) n_avg++;
  end
  task automatic chk(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rreg(input logic [7:0] a);
    @(posedge clk_i);
    {rd_i, addr_i} <= {1'b1, a};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask
  task automatic t_reset();
    rreg(REG_CTRL);
    chk("ctrl", v, 32'h0000_0050);
    rreg(REG_COUNT);
    chk("count", v, COUNT_RST);
    rreg(REG_WHI);
    chk("win high", v, WIN_HI_RST);
    rreg(8'h30);
    chk("unmapped", v, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_enc();
    logic [31:0] p;
    u_far.step(1, 8);
    rreg(8'h4C);
    chk("pos up", v, 32'h0000_0008);
    u_far.step(0, 3);
    rreg(8'h4C);
    chk("pos down", v, 32'h0000_0005);
    wreg(8'h40, 32'h0000_0001);
    rreg(8'h4C);
    p = v;
    u_far.step(1, 4);
    rreg(8'h4C);
    chk("pos single", v, p + 32'h0000_0001);
    wreg(8'h44, 32'h1234_5678);
    wreg(REG_CMD, 32'h0000_0002);
    rreg(8'h4C);
    chk("soft load", v, 32'h1234_5678);
    wreg(8'h40, 32'h0000_0007);
    wreg(8'h44, 32'h0000_0000);
    wreg(REG_CMD, 32'h0000_0002);
    rreg(8'h4C);
    chk("load ignored", v, 32'h1234_5678);
    u_far.mark();
    rreg(8'h4C);
    chk("first marker", v, 32'h0000_0000);
    u_far.step(1, 2);
    u_far.mark();
    rreg(8'h4C);
    chk("marker ignored", v, 32'h0000_0002);
    wreg(REG_CMD, 32'h0000_0010);
    u_far.mark();
    rreg(8'h4C);
    chk("rearmed", v, 32'h0000_0000);
    wreg(8'h40, 32'h0000_000B);
    u_far.step(1, 1);
    u_far.mark();
    rreg(8'h4C);
    chk("every marker", v, 32'h0000_0000);
    wreg(REG_STEP, 32'h0000_0002);
    wreg(REG_CTRL, 32'h0000_0054);
    n_rel = 0;
    u_far.step(1, 2);
    ticks(2);
    chk("step trigger", n_rel, 1);
    wreg(REG_WLO, 32'hFFFF_0000);
    u_far.step(1, 2);
    ticks(2);
    chk("below window", n_rel, 1);
    $display("test encoder done");
  endtask
  task automatic t_pin();
    wreg(REG_CTRL, 32'h0000_0042);
    n_rel = 0;
    u_far.set_pin(1'b1);
    ticks(2);
    chk("rise ignored", n_rel, 0);
    u_far.set_pin(1'b0);
    ticks(3);
    chk("fall release", n_rel, 1);
    wreg(REG_CTRL, 32'h0000_0059);
    n_rel = 0;
    u_far.set_sync(1'b1);
    ticks(3);
    chk("level high", n_rel, 3);
    u_far.set_sync(1'b0);
    ticks(2);
    chk("level low", n_rel, 3);
    $display("test pin done");
  endtask
  task automatic t_soft();
    logic [31:0] p;
    wreg(REG_CTRL, 32'h0000_0053);
    wreg(REG_COUNT, 32'h0000_0002);
    {n_rel, n_avg} = '0;
    wreg(REG_CMD, 32'h0000_0001);
    ticks(4);
    chk("burst", n_rel, 2);
    chk("restart", n_avg, 1);
    wreg(REG_CTRL, 32'h0000_0050);
    n_rel = 0;
    wreg(REG_CMD, 32'h0000_0001);
    ticks(3);
    chk("no source", n_rel, 0);
    wreg(REG_CTRL, 32'h0000_0053);
    wreg(REG_COUNT, COUNT_INF);
    n_rel = 0;
    wreg(REG_CMD, 32'h0000_0001);
    ticks(5);
    chk("endless", n_rel, 5);
    chk("acq gate", gate, 32'h0000_0001);
    wreg(REG_CTRL, 32'h0000_0073);
    n_avg = 0;
    wreg(REG_CMD, 32'h0000_0001);
    ticks(1);
    chk("out restart", n_avg, 0);
    chk("out gate", gate, 32'h0000_0000);
    rreg(REG_SCNT);
    p = v;
    wreg(REG_CMD, 32'h0000_0180);
    ticks(1);
    rreg(REG_SCNT);
    chk("count kept", v, p + 32'h0000_0001);
    wreg(REG_CMD, 32'h0000_0001);
    rreg(REG_SCNT);
    chk("count cleared", v, 32'h0000_0000);
    rreg(REG_TSTAMP);
    chk("stamp cleared", v, 32'h0000_0000);
    $display("test soft done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #500_000;
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_enc();
    t_pin();
    t_soft();
    end_of_test();
  end
endmodule // test_measurement_trigger_and_encoder_unit
